//--- src/agen_pkg.sv
package agen_pkg;

  // Address space geometry
  localparam int ADDR_W = 20;
  localparam logic [3:0] TOP_WINDOW_NIBBLE = 4'hf;
  localparam logic [3:0] SHORT_TARGET_NIBBLE = 4'h0;

  // Reset values of the registered outputs
  localparam logic [19:0] ADDR_RESET = 20'h00000;
  localparam logic FLAG_RESET = 1'b0;

  // Address modes presented by instruction decode
  typedef enum logic [2:0] {
    MODE_REL8 = 3'b000,
    MODE_REL16 = 3'b001,
    MODE_IMM20 = 3'b010,
    MODE_IMM16 = 3'b011,
    MODE_BASED_PTR_BYTE = 3'b100,
    MODE_BASED_WORD_REG8 = 3'b101,
    MODE_BASED_WORD_REG16 = 3'b110
  } addr_mode_t;

  // Base register choice for the pointer plus byte form
  localparam logic [1:0] BASE_POINTER_PAIR_A = 2'h0;
  localparam logic [1:0] BASE_POINTER_PAIR_B = 2'h1;
  localparam logic [1:0] BASE_STACK_POINTER = 2'h2;

  // Byte register choice for the word plus byte register form
  localparam logic BYTE_REG_B = 1'b0;
  localparam logic BYTE_REG_C = 1'b1;

  // All state of the generator
  typedef struct packed {
    logic pc_load;
    logic [19:0] pc_target;
    logic operand_valid;
    logic [19:0] operand_addr;
    logic reject;
  } agen_state_t;

  // Sign extension of the two displacement widths
  function automatic logic [19:0] sext8_20(input logic [7:0] d);
    sext8_20 = {{12{d[7]}}, d};
  endfunction

  function automatic logic [19:0] sext16_20(input logic [15:0] d);
    sext16_20 = {{4{d[15]}}, d};
  endfunction

  // Relative target; the carry out of bit 19 is dropped
  function automatic logic [19:0] rel_target(input logic [19:0] next_pc, input logic [19:0] disp);
    logic [20:0] sum;
    sum = {1'b0, next_pc} + {1'b0, disp};
    rel_target = sum[19:0];
  endfunction

endpackage

//--- src/based_sum.sv
`timescale 1ns/1ps
module based_sum
  import agen_pkg::*;
(
  input wire logic [15:0] base,
  input wire logic [15:0] offset,
  input wire logic use_bank,
  input wire logic [3:0] bank,
  output logic [19:0] addr
);

  logic [16:0] low_sum;

  // The low half wraps inside 64 KB; the high nibble is the window or the bank
  always_comb begin
    low_sum = {1'b0, base} + {1'b0, offset};
    addr = {(use_bank ? bank : TOP_WINDOW_NIBBLE), low_sum[15:0]};
  end

endmodule

//--- src/branch_and_based_address_gen.sv
`timescale 1ns/1ps
module branch_and_based_address_gen
  import agen_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic REQ_VALID,
  input wire logic [2:0] REQ_MODE,
  input wire logic IS_BRANCH,
  input wire logic [19:0] NEXT_PC,
  input wire logic [15:0] INSTR_DISP,
  input wire logic [19:0] INSTR_IMM,
  input wire logic [15:0] INSTR_OFFSET,
  input wire logic [1:0] BASE_SEL,
  input wire logic BYTE_REG_SEL,
  input wire logic [15:0] POINTER_PAIR_A,
  input wire logic [15:0] POINTER_PAIR_B,
  input wire logic [15:0] STACK_POINTER,
  input wire logic [7:0] REG_B,
  input wire logic [7:0] REG_C,
  input wire logic [15:0] REG_BC,
  input wire logic BANK_PREFIX,
  input wire logic [3:0] UPPER_BANK_REGISTER,
  output logic PC_LOAD,
  output logic [19:0] PC_TARGET,
  output logic OPERAND_VALID,
  output logic [19:0] OPERAND_ADDR,
  output logic REJECT
);

  agen_state_t st_r;
  agen_state_t st_nxt;
  addr_mode_t mode;
  logic [15:0] base_val;
  logic [15:0] offset_val;
  logic use_bank;
  logic [19:0] based_addr;

  assign mode = addr_mode_t'(REQ_MODE);

  // Operand selection per based form
  always_comb begin
    base_val = 16'h0000;
    offset_val = 16'h0000;
    case (mode)
      MODE_BASED_PTR_BYTE: begin
        case (BASE_SEL)
          BASE_POINTER_PAIR_A: base_val = POINTER_PAIR_A;
          BASE_POINTER_PAIR_B: base_val = POINTER_PAIR_B;
          BASE_STACK_POINTER: base_val = STACK_POINTER;
          default: base_val = 16'h0000;
        endcase
        offset_val = {8'h00, INSTR_OFFSET[7:0]};
      end
      MODE_BASED_WORD_REG8: begin
        base_val = INSTR_OFFSET;
        offset_val = {8'h00, (BYTE_REG_SEL == BYTE_REG_C) ? REG_C : REG_B};
      end
      MODE_BASED_WORD_REG16: begin
        base_val = INSTR_OFFSET;
        offset_val = REG_BC;
      end
      default: begin
        base_val = 16'h0000;
        offset_val = 16'h0000;
      end
    endcase
  end

  // No bank form exists for the stack pointer, so the prefix is ignored there
  assign use_bank = BANK_PREFIX && !(mode == MODE_BASED_PTR_BYTE && BASE_SEL == BASE_STACK_POINTER);

  based_sum u_based_sum (
    .base(base_val),
    .offset(offset_val),
    .use_bank(use_bank),
    .bank(UPPER_BANK_REGISTER),
    .addr(based_addr)
  );

  // Next state: every flag is a one-cycle pulse, addresses hold until replaced
  always_comb begin
    st_nxt = st_r;
    st_nxt.pc_load = 1'b0;
    st_nxt.operand_valid = 1'b0;
    st_nxt.reject = 1'b0;
    if (REQ_VALID) begin
      case (mode)
        MODE_REL8: begin
          if (IS_BRANCH) begin
            st_nxt.pc_load = 1'b1;
            st_nxt.pc_target = rel_target(NEXT_PC, sext8_20(INSTR_DISP[7:0]));
          end else begin
            st_nxt.reject = 1'b1;
          end
        end
        MODE_REL16: begin
          if (IS_BRANCH) begin
            st_nxt.pc_load = 1'b1;
            st_nxt.pc_target = rel_target(NEXT_PC, sext16_20(INSTR_DISP));
          end else begin
            st_nxt.reject = 1'b1;
          end
        end
        MODE_IMM20: begin
          st_nxt.pc_load = 1'b1;
          st_nxt.pc_target = INSTR_IMM;
        end
        MODE_IMM16: begin
          st_nxt.pc_load = 1'b1;
          st_nxt.pc_target = {SHORT_TARGET_NIBBLE, INSTR_IMM[15:0]};
        end
        MODE_BASED_PTR_BYTE, MODE_BASED_WORD_REG8, MODE_BASED_WORD_REG16: begin
          st_nxt.operand_valid = 1'b1;
          st_nxt.operand_addr = based_addr;
        end
        default: begin
          // Unknown mode code: refuse rather than guess a target
          st_nxt.reject = 1'b1;
        end
      endcase
    end
  end

  // State register with synchronous reset
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      st_r.pc_load <= FLAG_RESET;
      st_r.pc_target <= ADDR_RESET;
      st_r.operand_valid <= FLAG_RESET;
      st_r.operand_addr <= ADDR_RESET;
      st_r.reject <= FLAG_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state flops
  assign PC_LOAD = st_r.pc_load;
  assign PC_TARGET = st_r.pc_target;
  assign OPERAND_VALID = st_r.operand_valid;
  assign OPERAND_ADDR = st_r.operand_addr;
  assign REJECT = st_r.reject;

  // Checks on the registered answer one cycle after each request or idle cycle
  property p_rel8_target;
    @(posedge CLOCK) disable iff (!RESETN)
    (REQ_VALID && REQ_MODE == MODE_REL8 && IS_BRANCH) |=>
      (PC_LOAD && PC_TARGET == rel_target($past(NEXT_PC), sext8_20($past(INSTR_DISP[7:0]))));
  endproperty
  a_rel8_target: assert property (p_rel8_target) else $error("8-bit relative target wrong");

  property p_rel16_next_pc;
    @(posedge CLOCK) disable iff (!RESETN)
    (REQ_VALID && REQ_MODE == MODE_REL16 && IS_BRANCH) |=>
      (PC_LOAD && !REJECT && PC_TARGET == rel_target($past(NEXT_PC), sext16_20($past(INSTR_DISP))));
  endproperty
  a_rel16_next_pc: assert property (p_rel16_next_pc) else $error("16-bit relative target wrong");

  property p_rel_non_branch;
    @(posedge CLOCK) disable iff (!RESETN)
    (REQ_VALID && (REQ_MODE == MODE_REL8 || REQ_MODE == MODE_REL16) && !IS_BRANCH) |=>
      (REJECT && !PC_LOAD && $stable(PC_TARGET));
  endproperty
  a_rel_non_branch: assert property (p_rel_non_branch) else $error("relative mode used by non-branch");

  property p_imm20;
    @(posedge CLOCK) disable iff (!RESETN)
    (REQ_VALID && REQ_MODE == MODE_IMM20) |=> (PC_LOAD && PC_TARGET == $past(INSTR_IMM));
  endproperty
  a_imm20: assert property (p_imm20) else $error("20-bit immediate target altered");

  property p_imm16;
    @(posedge CLOCK) disable iff (!RESETN)
    (REQ_VALID && REQ_MODE == MODE_IMM16) |=>
      (PC_LOAD && PC_TARGET[19:16] == 4'h0 && PC_TARGET[15:0] == $past(INSTR_IMM[15:0]));
  endproperty
  a_imm16: assert property (p_imm16) else $error("16-bit immediate target upper bits not zero");

  property p_based_window;
    @(posedge CLOCK) disable iff (!RESETN)
    (REQ_VALID && !BANK_PREFIX && (REQ_MODE == MODE_BASED_PTR_BYTE || REQ_MODE == MODE_BASED_WORD_REG8)) |=>
      (OPERAND_VALID && OPERAND_ADDR[19:16] == 4'hf);
  endproperty
  a_based_window: assert property (p_based_window) else $error("byte based address left top window");

  property p_word_bc_window;
    @(posedge CLOCK) disable iff (!RESETN)
    (REQ_VALID && !BANK_PREFIX && REQ_MODE == MODE_BASED_WORD_REG16) |=>
      (OPERAND_VALID && OPERAND_ADDR == {4'hf, $past(INSTR_OFFSET) + $past(REG_BC)});
  endproperty
  a_word_bc_window: assert property (p_word_bc_window) else $error("word plus pair address wrong");

  property p_bank_prefix;
    @(posedge CLOCK) disable iff (!RESETN)
    (REQ_VALID && BANK_PREFIX && (REQ_MODE == MODE_BASED_WORD_REG8 || REQ_MODE == MODE_BASED_WORD_REG16)) |=>
      (OPERAND_VALID && OPERAND_ADDR[19:16] == $past(UPPER_BANK_REGISTER));
  endproperty
  a_bank_prefix: assert property (p_bank_prefix) else $error("bank nibble not taken from bank register");

  property p_ptr_byte_sum;
    @(posedge CLOCK) disable iff (!RESETN)
    (REQ_VALID && REQ_MODE == MODE_BASED_PTR_BYTE && BASE_SEL == BASE_POINTER_PAIR_A) |=>
      (OPERAND_ADDR[15:0] == $past(POINTER_PAIR_A) + {8'h00, $past(INSTR_OFFSET[7:0])});
  endproperty
  a_ptr_byte_sum: assert property (p_ptr_byte_sum) else $error("pointer plus byte sum wrong");

  property p_idle_quiet;
    @(posedge CLOCK) disable iff (!RESETN)
    !REQ_VALID |=> (!PC_LOAD && !OPERAND_VALID && !REJECT && $stable(PC_TARGET) && $stable(OPERAND_ADDR));
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("output pulse without request");

  // Further checks on the based forms and on which outputs a request may touch
  property p_ptr_pair_b_sum;
    @(posedge CLOCK) disable iff (!RESETN)
    (REQ_VALID && REQ_MODE == MODE_BASED_PTR_BYTE && BASE_SEL == BASE_POINTER_PAIR_B) |=>
      (OPERAND_VALID && OPERAND_ADDR[15:0] == $past(POINTER_PAIR_B) + {8'h00, $past(INSTR_OFFSET[7:0])});
  endproperty
  a_ptr_pair_b_sum: assert property (p_ptr_pair_b_sum) else $error("second pointer plus byte sum wrong");

  property p_stack_window;
    @(posedge CLOCK) disable iff (!RESETN)
    (REQ_VALID && REQ_MODE == MODE_BASED_PTR_BYTE && BASE_SEL == BASE_STACK_POINTER) |=>
      (OPERAND_VALID && OPERAND_ADDR == {4'hf, $past(STACK_POINTER) + {8'h00, $past(INSTR_OFFSET[7:0])}});
  endproperty
  a_stack_window: assert property (p_stack_window) else $error("stack pointer address left top window");

  property p_bank_ptr_byte;
    @(posedge CLOCK) disable iff (!RESETN)
    (REQ_VALID && BANK_PREFIX && REQ_MODE == MODE_BASED_PTR_BYTE && BASE_SEL != BASE_STACK_POINTER) |=>
      (OPERAND_VALID && OPERAND_ADDR[19:16] == $past(UPPER_BANK_REGISTER));
  endproperty
  a_bank_ptr_byte: assert property (p_bank_ptr_byte) else $error("prefixed pointer form missed bank nibble");

  property p_reg_c_sum;
    @(posedge CLOCK) disable iff (!RESETN)
    (REQ_VALID && REQ_MODE == MODE_BASED_WORD_REG8 && BYTE_REG_SEL == BYTE_REG_C) |=>
      (OPERAND_VALID && OPERAND_ADDR[15:0] == $past(INSTR_OFFSET) + {8'h00, $past(REG_C)});
  endproperty
  a_reg_c_sum: assert property (p_reg_c_sum) else $error("word plus second byte register wrong");

  property p_reg_b_sum;
    @(posedge CLOCK) disable iff (!RESETN)
    (REQ_VALID && REQ_MODE == MODE_BASED_WORD_REG8 && BYTE_REG_SEL == BYTE_REG_B) |=>
      (OPERAND_VALID && OPERAND_ADDR[15:0] == $past(INSTR_OFFSET) + {8'h00, $past(REG_B)});
  endproperty
  a_reg_b_sum: assert property (p_reg_b_sum) else $error("word plus first byte register wrong");

  property p_spare_base;
    @(posedge CLOCK) disable iff (!RESETN)
    (REQ_VALID && REQ_MODE == MODE_BASED_PTR_BYTE && BASE_SEL == 2'h3) |=>
      (OPERAND_VALID && OPERAND_ADDR[15:0] == {8'h00, $past(INSTR_OFFSET[7:0])});
  endproperty
  a_spare_base: assert property (p_spare_base) else $error("spare base select not zero based");

  property p_illegal_mode;
    @(posedge CLOCK) disable iff (!RESETN)
    (REQ_VALID && REQ_MODE == 3'h7) |=>
      (REJECT && !PC_LOAD && !OPERAND_VALID && $stable(PC_TARGET) && $stable(OPERAND_ADDR));
  endproperty
  a_illegal_mode: assert property (p_illegal_mode) else $error("spare mode code not refused");

  property p_one_answer;
    @(posedge CLOCK) disable iff (!RESETN)
    $onehot0({PC_LOAD, OPERAND_VALID, REJECT});
  endproperty
  a_one_answer: assert property (p_one_answer) else $error("more than one answer pulse at once");

  property p_pc_keeps_operand;
    @(posedge CLOCK) disable iff (!RESETN)
    (REQ_VALID && (REQ_MODE == MODE_IMM20 || REQ_MODE == MODE_IMM16)) |=>
      (!OPERAND_VALID && !REJECT && $stable(OPERAND_ADDR));
  endproperty
  a_pc_keeps_operand: assert property (p_pc_keeps_operand) else $error("immediate jump touched operand");

  property p_based_keeps_pc;
    @(posedge CLOCK) disable iff (!RESETN)
    (REQ_VALID && REQ_MODE inside {MODE_BASED_PTR_BYTE, MODE_BASED_WORD_REG8, MODE_BASED_WORD_REG16}) |=>
      (!PC_LOAD && !REJECT && $stable(PC_TARGET));
  endproperty
  a_based_keeps_pc: assert property (p_based_keeps_pc) else $error("based operand touched branch target");

  property p_word_bc_bank_low;
    @(posedge CLOCK) disable iff (!RESETN)
    (REQ_VALID && BANK_PREFIX && REQ_MODE == MODE_BASED_WORD_REG16) |=>
      (OPERAND_VALID && OPERAND_ADDR[15:0] == $past(INSTR_OFFSET) + $past(REG_BC));
  endproperty
  a_word_bc_bank_low: assert property (p_word_bc_bank_low) else $error("prefixed word plus pair sum wrong");

endmodule

//--- tb/branch_and_based_address_gen_tb_top.sv
`timescale 1ns/1ps
module branch_and_based_address_gen_tb_top
  import agen_pkg::*;
;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic req_valid = 1'b0;
  logic is_branch = 1'b0;
  logic byte_sel = 1'b0;
  logic prefix = 1'b0;
  logic [1:0] base_sel = 2'h0;
  logic [2:0] req_mode = 3'h0;
  logic [3:0] ub = 4'h0;
  logic [7:0] reg_b = 8'h00;
  logic [7:0] reg_c = 8'h00;
  logic [19:0] next_pc = 20'h00000;
  logic [19:0] imm = 20'h00000;
  logic [15:0] disp = 16'h0000;
  logic [15:0] offset = 16'h0000;
  logic [15:0] ptr_a = 16'h0000;
  logic [15:0] ptr_b = 16'h0000;
  logic [15:0] sp = 16'h0000;
  logic [15:0] reg_bc = 16'h0000;
  logic pc_load, operand_valid, reject;
  logic [19:0] pc_target, operand_addr;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;

  branch_and_based_address_gen dut (
    .CLOCK(clock), .RESETN(resetn), .REQ_VALID(req_valid), .REQ_MODE(req_mode), .IS_BRANCH(is_branch),
    .NEXT_PC(next_pc), .INSTR_DISP(disp), .INSTR_IMM(imm), .INSTR_OFFSET(offset), .BASE_SEL(base_sel),
    .BYTE_REG_SEL(byte_sel), .POINTER_PAIR_A(ptr_a), .POINTER_PAIR_B(ptr_b), .STACK_POINTER(sp),
    .REG_B(reg_b), .REG_C(reg_c), .REG_BC(reg_bc), .BANK_PREFIX(prefix), .UPPER_BANK_REGISTER(ub),
    .PC_LOAD(pc_load), .PC_TARGET(pc_target), .OPERAND_VALID(operand_valid), .OPERAND_ADDR(operand_addr),
    .REJECT(reject));

  // Free running clock, 10 ns period
  always #5 clock = ~clock;

  // Hang guard: the whole run needs well under a hundred cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 500) begin
      num_errors++;
      conclude();
    end
  end

  task automatic conclude;
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic cmp_addr(input logic [19:0] got, input logic [19:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Flags in the order load, operand valid, reject
  task automatic cmp_flags(input logic [2:0] exp);
    num_checks++;
    if ({pc_load, operand_valid, reject} !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, {pc_load, operand_valid, reject}, exp);
    end
  endtask

  // One request, answer looked at just after the edge that produces it
  task automatic go(input logic [2:0] m);
    req_mode <= m;
    req_valid <= 1'b1;
    @(posedge clock);
    req_valid <= 1'b0;
    #1;
  endtask

  task automatic pc_req(input logic [2:0] m, input logic br, input logic [19:0] npc, input logic [15:0] d);
    @(posedge clock);
    is_branch <= br;
    next_pc <= npc;
    disp <= d;
    imm <= npc;
    go(m);
  endtask

  task automatic op_req(input logic [2:0] m, input logic [1:0] bs, input logic ys, input logic [15:0] o,
                        input logic p);
    @(posedge clock);
    base_sel <= bs;
    byte_sel <= ys;
    offset <= o;
    prefix <= p;
    go(m);
  endtask

  // Relative targets; upper displacement bits are junk in the short form
  task automatic t_rel;
    pc_req(MODE_REL8, 1'b1, 20'h00102, 16'habfe);
    cmp_flags(3'b100);
    cmp_addr(pc_target, 20'h00100);
    pc_req(MODE_REL8, 1'b1, 20'h10000, 16'h547f);
    cmp_addr(pc_target, 20'h1007f);
    pc_req(MODE_REL16, 1'b1, 20'h08000, 16'h8000);
    cmp_addr(pc_target, 20'h00000);
    pc_req(MODE_REL16, 1'b1, 20'hfffff, 16'h0002);
    cmp_addr(pc_target, 20'h00001);
  endtask

  // Non-branch relative and the spare code are refused, target untouched
  task automatic t_refuse;
    pc_req(MODE_REL8, 1'b0, 20'h22222, 16'h0010);
    cmp_flags(3'b001);
    cmp_addr(pc_target, 20'h00001);
    pc_req(MODE_REL16, 1'b0, 20'h22222, 16'h0010);
    cmp_flags(3'b001);
    pc_req(3'h7, 1'b1, 20'h33333, 16'h0010);
    cmp_flags(3'b001);
  endtask

  // Immediate targets are taken from the immediate field
  task automatic t_imm;
    pc_req(MODE_IMM20, 1'b0, 20'habcde, 16'h0000);
    cmp_flags(3'b100);
    cmp_addr(pc_target, 20'habcde);
    pc_req(MODE_IMM16, 1'b0, 20'h51234, 16'h0000);
    cmp_addr(pc_target, 20'h01234);
  endtask

  // Based forms with distinct register contents so a wrong pick shows
  task automatic t_based;
    @(posedge clock);
    ptr_a <= 16'h1000;
    ptr_b <= 16'h2200;
    sp <= 16'hfe00;
    reg_b <= 8'h20;
    reg_c <= 8'h10;
    reg_bc <= 16'h1234;
    ub <= 4'h3;
    op_req(MODE_BASED_PTR_BYTE, 2'h0, 1'b0, 16'h12ff, 1'b0);
    cmp_flags(3'b010);
    cmp_addr(operand_addr, 20'hf10ff);
    op_req(MODE_BASED_PTR_BYTE, 2'h1, 1'b0, 16'h0005, 1'b1);
    cmp_addr(operand_addr, 20'h32205);
    op_req(MODE_BASED_PTR_BYTE, 2'h2, 1'b0, 16'h0010, 1'b1);
    cmp_addr(operand_addr, 20'hffe10);
    op_req(MODE_BASED_PTR_BYTE, 2'h3, 1'b0, 16'h0044, 1'b0);
    cmp_addr(operand_addr, 20'hf0044);
    op_req(MODE_BASED_WORD_REG8, 2'h0, 1'b1, 16'h1000, 1'b0);
    cmp_addr(operand_addr, 20'hf1010);
    op_req(MODE_BASED_WORD_REG8, 2'h0, 1'b0, 16'h1000, 1'b1);
    cmp_addr(operand_addr, 20'h31020);
    op_req(MODE_BASED_WORD_REG16, 2'h0, 1'b0, 16'h8000, 1'b0);
    cmp_addr(operand_addr, 20'hf9234);
    op_req(MODE_BASED_WORD_REG16, 2'h0, 1'b0, 16'hf000, 1'b0);
    cmp_addr(operand_addr, 20'hf0234);
    op_req(MODE_BASED_WORD_REG16, 2'h0, 1'b0, 16'h8000, 1'b1);
    cmp_addr(operand_addr, 20'h39234);
    cmp_addr(pc_target, 20'h01234);
  endtask

  // Reset for three edges, outputs must be clear as it is released
  initial begin
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    #1;
    cmp_flags(3'b000);
    cmp_addr(pc_target, ADDR_RESET);
    cmp_addr(operand_addr, ADDR_RESET);
    @(posedge clock);
    t_rel();
    t_refuse();
    t_imm();
    t_based();
    conclude();
  end
endmodule
